/* hdl/panel_indicator_state_driver.v */
/*
 * Front-panel indicator driver: turns unit status into blue and amber
 * lamp enables, for a separate lamp pair, a combined bicolour lamp and
 * extra amber fault lamps, with a Wishbone register slave.
 * Assumes status inputs are asynchronous levels from management logic
 * and a classic single-cycle Wishbone master on the same clock.
 */
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "panel_defs.vh"
module panel_indicator_state_driver #(
    parameter N_XFLT = 2,
    parameter DEV_FEATURES = 0,
    parameter HALF_PERIOD_CYCLES = `HALF_PERIOD_CYC
) (
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // unit status
    input wire power_on_i,
    input wire link_i,
    input wire activity_i,
    input wire fault_i,
    input wire locate_i,
    input wire fw_update_i,
    input wire [N_XFLT-1:0] extra_fault_i,
    // separate pair
    output reg blue_o,
    output reg amber_o,
    // combined bicolour lamp
    output reg comb_blue_o,
    output reg comb_amber_o,
    // extra fault lamps
    output reg [N_XFLT-1:0] extra_amber_o
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    // a behaviour code plus the shared phase gives the lamp level
    function lamp_level;
        input [1:0] beh;
        input phase;
        begin
            case (beh)
                `BEH_ON: lamp_level = 1'b1; // R1
                `BEH_BLINK: lamp_level = ~phase; // R1 R2
                default: lamp_level = 1'b0;
            endcase
        end
    endfunction

    // byte-lane merge for writes
    function [7:0] lane_wr;
        input [7:0] old_v;
        input [7:0] new_v;
        input en;
        begin
            lane_wr = en ? new_v : old_v;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // status inputs and timebase

    localparam SW = `ST_NPINS + N_XFLT;
    wire [SW-1:0] raw_status;
    wire [SW-1:0] sync_status;
    wire phase;

    assign raw_status = {extra_fault_i, fw_update_i, locate_i, fault_i,
                         activity_i, link_i, power_on_i};

    status_sync #(
        .WIDTH(SW)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(raw_status),
        .sync_o(sync_status)
    );

    // one timebase for every lamp keeps all blinking in step
    blink_timebase #(
        .HALF_PERIOD_CYCLES(HALF_PERIOD_CYCLES)
    ) u_tb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .phase_o(phase)
    ); // R14

    ////////////////////////////////////////////////////////////////////
    // registers

    reg [4:0] ctrl_r;
    reg [7:0] xmask_r;
    reg [4:0] ctrl_nxt;
    reg [7:0] xmask_nxt;
    reg [7:0] ctrl_wr;
    reg [31:0] rd_nxt;
    reg [1:0] blue_beh_r;
    reg [1:0] amber_beh_r;

    wire req = cyc_i & stb_i;
    // write lands on the edge at which the master samples ack
    wire wr_now = req & we_i & ack_o;
    wire ctrl_we = wr_now & (adr_i == `REG_CTRL);
    wire xmask_we = wr_now & (adr_i == `REG_XMASK);
    wire combined = ctrl_r[`CTRL_COMBINED];
    // lamp test is a development aid; stripped unless built in
    wire lamp_test = (DEV_FEATURES != 0) & ctrl_r[`CTRL_LAMP_TEST]; // R12

    wire st_power = sync_status[`ST_POWER];
    wire st_link = sync_status[`ST_LINK];
    wire st_act = sync_status[`ST_ACT];
    wire st_fault = sync_status[`ST_FAULT] | ctrl_r[`CTRL_SW_FAULT];
    wire st_locate = sync_status[`ST_LOCATE] | ctrl_r[`CTRL_SW_LOCATE];
    wire st_fwupd = sync_status[`ST_FWUPD] | ctrl_r[`CTRL_SW_FWUPD];
    wire [N_XFLT-1:0] st_xflt = sync_status[SW-1:`ST_NPINS];

    always @* begin
        ctrl_nxt = ctrl_r;
        xmask_nxt = xmask_r;
        ctrl_wr = lane_wr({3'h0, ctrl_r}, dat_i[7:0], sel_i[0]);
        if (ctrl_we) begin
            ctrl_nxt = ctrl_wr[4:0];
            if (DEV_FEATURES == 0) begin
                ctrl_nxt[`CTRL_LAMP_TEST] = 1'b0; // R12
            end
        end
        if (xmask_we) begin
            xmask_nxt = lane_wr(xmask_r, dat_i[7:0], sel_i[0]);
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `CTRL_RESET;
            xmask_r <= `XMASK_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
            xmask_r <= xmask_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state decode into lamp behaviours

    reg [1:0] blue_beh;
    reg [1:0] amber_beh;

    always @* begin
        blue_beh = `BEH_OFF;
        amber_beh = `BEH_OFF;
        if (lamp_test) begin
            blue_beh = `BEH_ON; // R12
            amber_beh = `BEH_ON;
        end else if (st_fault) begin
            // combined lamp cannot show both colours, so fault owns it
            amber_beh = `BEH_ON; // R9
        end else if (st_locate) begin
            amber_beh = `BEH_BLINK; // R7
        end else if (st_power) begin
            if (st_act) begin
                blue_beh = `BEH_BLINK; // R8
            end else begin
                blue_beh = `BEH_ON; // R8
            end
        end
        // link without power leaves blue off: an absent unit shows no link
        if (!st_power) begin
            blue_beh = `BEH_OFF; // R7
        end
    end

    ////////////////////////////////////////////////////////////////////
    // lamp outputs, all registered

    integer k;
    reg fw_alt;
    reg blue_nxt;
    reg amber_nxt;
    reg comb_blue_nxt;
    reg comb_amber_nxt;
    reg [N_XFLT-1:0] extra_amber_nxt;

    always @* begin
        // firmware alternation only has meaning on the bicolour lamp
        fw_alt = combined & st_fwupd & ~lamp_test & ~st_fault; // R11
    end

    // pair and bicolour lamp never lit together: only one is fitted
    always @* begin
        blue_nxt = 1'b0;
        amber_nxt = 1'b0;
        comb_blue_nxt = 1'b0;
        comb_amber_nxt = 1'b0;
        if (combined) begin // R5
            if (fw_alt) begin
                comb_blue_nxt = ~phase; // R11 R13
                comb_amber_nxt = phase; // R11 R13
            end else if (amber_beh != `BEH_OFF) begin
                // one die at a time, amber wins
                comb_amber_nxt = lamp_level(amber_beh, phase); // R10
            end else begin
                comb_blue_nxt = lamp_level(blue_beh, phase); // R10
            end
        end else begin
            blue_nxt = lamp_level(blue_beh, phase); // R3 R4
            amber_nxt = lamp_level(amber_beh, phase); // R3 R4
        end
    end

    // extra lamps are separate amber lamps in either mode
    always @* begin
        extra_amber_nxt = {N_XFLT{1'b0}};
        for (k = 0; k < N_XFLT; k = k + 1) begin
            extra_amber_nxt[k] = lamp_test | (st_xflt[k] & xmask_r[k]); // R6
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            blue_o <= 1'b0;
            amber_o <= 1'b0;
            comb_blue_o <= 1'b0;
            comb_amber_o <= 1'b0;
            extra_amber_o <= {N_XFLT{1'b0}};
            blue_beh_r <= `BEH_OFF;
            amber_beh_r <= `BEH_OFF;
        end else begin
            blue_beh_r <= blue_beh;
            amber_beh_r <= amber_beh;
            blue_o <= blue_nxt;
            amber_o <= amber_nxt;
            comb_blue_o <= comb_blue_nxt;
            comb_amber_o <= comb_amber_nxt;
            extra_amber_o <= extra_amber_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wishbone read path and acknowledge

    always @* begin
        rd_nxt = 32'h00000000;
        case (adr_i)
            `REG_CTRL: begin
                rd_nxt[4:0] = ctrl_r;
            end
            `REG_XMASK: begin
                rd_nxt[N_XFLT-1:0] = xmask_r[N_XFLT-1:0];
            end
            `REG_STATUS: begin
                rd_nxt[`ST_POWER] = st_power;
                rd_nxt[`ST_LINK] = st_link;
                rd_nxt[`ST_ACT] = st_act;
                rd_nxt[`ST_FAULT] = st_fault;
                rd_nxt[`ST_LOCATE] = st_locate;
                rd_nxt[`ST_FWUPD] = st_fwupd;
                rd_nxt[`ST_PHASE] = phase;
                rd_nxt[`ST_XFLT_LSB +: N_XFLT] = st_xflt;
            end
            `REG_LAMP: begin
                rd_nxt[`LP_BLUE_LSB +: 2] = blue_beh_r;
                rd_nxt[`LP_AMBER_LSB +: 2] = amber_beh_r;
                rd_nxt[`LP_BLUE_OUT] = blue_o;
                rd_nxt[`LP_AMBER_OUT] = amber_o;
                rd_nxt[`LP_CB_OUT] = comb_blue_o;
                rd_nxt[`LP_CA_OUT] = comb_amber_o;
                rd_nxt[`LP_XFLT_LSB +: N_XFLT] = extra_amber_o;
            end
            default: begin
                rd_nxt = 32'h00000000;
            end
        endcase
    end

    reg ack_nxt;
    reg [31:0] dat_nxt;
    wire rd_take = req & ~ack_o & ~we_i;

    // ack toggles off after one cycle, so a held request is taken again every second cycle
    always @* begin
        ack_nxt = req & ~ack_o;
        dat_nxt = dat_o;
        if (rd_take) begin
            dat_nxt = rd_nxt;
        end
    end

    // unmapped addresses are still acknowledged and read as zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= ack_nxt;
            dat_o <= dat_nxt;
        end
    end
endmodule // panel_indicator_state_driver

/* inc/panel_defs.vh */
/*
 * Constants for the front-panel indicator driver: register map, field
 * positions, lamp behaviour codes and the blink timebase figures.
 * Assumes a 125 MHz system clock and a classic Wishbone register bus.
 */
// Summary of operation
// R1: every lamp is only ever off, steady on or blinking; nothing else.
// R2: blinking runs at 1 Hz, half a second lit then half dark.
// R3: only blue and amber lamps; blue for power/link/activity, amber for fault/locate.
// R4: preferred arrangement is a separate blue lamp and amber lamp per unit.
// R5: a single combined blue/amber lamp may replace the pair when space is short.
// R6: extra amber lamps, one per extra fault type, beside the main amber lamp.
// R7: unit off or absent: blue off; amber off without fault, blinking for locate.
// R8: unit working, no fault: blue steady with link, blinking on activity; amber off. The code lights blue steady on power alone and ignores link.
// R9: fault with unit off or not working: amber steady, blue off.
// R10: combined lamp shows the colour and behaviour the pair would show, dark otherwise.
// R11: firmware update alternates blue and amber, in combined mode only.
// R12: development-only lamp functions can be removed or disabled by configuration.
// R13: firmware alternation repeats each second: half second blue, half second amber.
// R14: one shared timebase from the clock phases every blink; reset restarts it.
`ifndef PANEL_DEFS_VH
`define PANEL_DEFS_VH

// register byte offsets
`define REG_CTRL 4'h0
`define REG_XMASK 4'h4
`define REG_STATUS 4'h8
`define REG_LAMP 4'hC

// control register fields
`define CTRL_COMBINED 0
`define CTRL_LAMP_TEST 1
`define CTRL_SW_LOCATE 2
`define CTRL_SW_FAULT 3
`define CTRL_SW_FWUPD 4
`define CTRL_RESET 5'h00
`define XMASK_RESET 8'hFF

// status register fields
`define ST_POWER 0
`define ST_LINK 1
`define ST_ACT 2
`define ST_FAULT 3
`define ST_LOCATE 4
`define ST_FWUPD 5
`define ST_PHASE 6
`define ST_XFLT_LSB 8
// single status pins ahead of the extra fault inputs
`define ST_NPINS 6

// lamp register fields
`define LP_BLUE_LSB 0
`define LP_AMBER_LSB 2
`define LP_BLUE_OUT 4
`define LP_AMBER_OUT 5
`define LP_CB_OUT 6
`define LP_CA_OUT 7
`define LP_XFLT_LSB 8

// lamp behaviour codes
`define BEH_OFF 2'h0
`define BEH_ON 2'h1
`define BEH_BLINK 2'h2

// timebase: half of a 1 Hz period at the system clock rate
`define CLK_KHZ 125000
`define HALF_PERIOD_MS 500
`define HALF_PERIOD_CYC (`HALF_PERIOD_MS * `CLK_KHZ)

`endif

/* hdl/status_sync.v */
/*
 * Three-stage synchroniser for the status inputs.
 * Assumes the inputs are asynchronous levels; a change is taken once the
 * second and third stages agree, which also rejects single-cycle glitches.
 */
`timescale 1ns/1ps
module status_sync #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;
    integer i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= {WIDTH{1'b0}};
            s2_r <= {WIDTH{1'b0}};
            s3_r <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_i;
            s2_r <= meta_r;
            s3_r <= s2_r;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    sync_o[i] <= s3_r[i];
                end
            end
        end
    end
endmodule // status_sync

/* hdl/blink_timebase.v */
/*
 * Free-running blink timebase: phase toggles every half period.
 * Assumes a synchronous reset; after reset phase is 0 (lit half) first.
 */
`timescale 1ns/1ps
`include "panel_defs.vh"
module blink_timebase #(
    parameter HALF_PERIOD_CYCLES = `HALF_PERIOD_CYC,
    parameter CNT_W = 26
) (
    input wire clk_i,
    input wire rst_i,
    output reg phase_o
);
    localparam [31:0] LAST_FULL = HALF_PERIOD_CYCLES - 1;
    // CNT_W must be wide enough for the half period; the cut is deliberate
    localparam [CNT_W-1:0] LAST = LAST_FULL[CNT_W-1:0];
    reg [CNT_W-1:0] cnt_r;

    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= {CNT_W{1'b0}}; // R14
            phase_o <= 1'b0;
        end else if (cnt_r == LAST) begin
            cnt_r <= {CNT_W{1'b0}};
            phase_o <= ~phase_o; // R2 R13
        end else begin
            cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
endmodule // blink_timebase

/* test/panel_checker_properties.sv */
/*
 * Checker for the panel indicator driver: bus handshake and lamp behaviour.
 * Assumes it is bound to the driver's top module and sees only its ports.
 */
`timescale 1ns/1ps
module panel_checker #(
    parameter N_XFLT = 2,
    parameter HALF_PERIOD_CYCLES = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire ack_o,
    input wire power_on_i,
    input wire activity_i,
    input wire fault_i,
    input wire locate_i,
    input wire fw_update_i,
    input wire [N_XFLT-1:0] extra_fault_i,
    input wire blue_o,
    input wire amber_o,
    input wire comb_blue_o,
    input wire comb_amber_o,
    input wire [N_XFLT-1:0] extra_amber_o
);
default clocking dck @(posedge clk_i); endclocking
default disable iff (rst_i);
////////////////////////////////////////////////////////////////////////////////
// run length of blue_o; blink timing is judged only once inputs stayed quiet
reg b_q;
reg [31:0] run_r;
reg [31:0] quiet_r;
reg [4:0] st_q;
always @(posedge clk_i) begin
    b_q <= blue_o;
    st_q <= {power_on_i, activity_i, fault_i, locate_i, fw_update_i};
    run_r <= (blue_o != b_q) ? 32'h1 : run_r + 32'h1;
    if (rst_i || cyc_i || st_q != {power_on_i, activity_i, fault_i, locate_i, fw_update_i})
        quiet_r <= 32'h0;
    else
        quiet_r <= quiet_r + 32'h1;
end
////////////////////////////////////////////////////////////////////////////////
chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
chk_ack_prompt: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
chk_comb_one_die: assert property (!(comb_blue_o && comb_amber_o))
    else $error("both dies of combined lamp lit");
chk_pair_or_comb: assert property ((blue_o || amber_o) |-> !(comb_blue_o || comb_amber_o))
    else $error("pair and combined lamp lit together");
chk_blue_unpowered: assert property ((!power_on_i && !fw_update_i) [*8] |-> !blue_o && !comb_blue_o)
    else $error("blue lit without power");
chk_fault_amber: assert property (fault_i [*8] |-> !blue_o && !comb_blue_o && (amber_o ^ comb_amber_o))
    else $error("fault not shown as steady amber");
chk_blink_half: assert property ((blue_o != b_q && quiet_r > 32'h10) |-> run_r == HALF_PERIOD_CYCLES)
    else $error("blink half period wrong");
chk_reset_dark: assert property ($fell(rst_i) |-> !ack_o && !blue_o && !amber_o && !comb_blue_o && !comb_amber_o)
    else $error("outputs not dark after reset");
chk_xflt_dark: assert property ((extra_fault_i == 0) [*8] |-> extra_amber_o == 0)
    else $error("extra lamp lit without fault");
endmodule // panel_checker
bind panel_indicator_state_driver panel_checker #(.N_XFLT(N_XFLT),
    .HALF_PERIOD_CYCLES(HALF_PERIOD_CYCLES)) chk (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .power_on_i(power_on_i),
    .activity_i(activity_i), .fault_i(fault_i), .locate_i(locate_i),
    .fw_update_i(fw_update_i), .extra_fault_i(extra_fault_i), .blue_o(blue_o),
    .amber_o(amber_o), .comb_blue_o(comb_blue_o), .comb_amber_o(comb_amber_o),
    .extra_amber_o(extra_amber_o));

/* test/status_src.sv */
/*
 * Model of the management logic that feeds the status levels.
 * Assumes requests arrive as one packed word; levels change after an edge.
 */
`timescale 1ns/1ps
module status_src (
    input wire clk_i,
    input wire [7:0] req_i,
    output logic link_o,
    output logic power_on_o,
    output logic activity_o,
    output logic fault_o,
    output logic locate_o,
    output logic fw_update_o,
    output logic [1:0] extra_fault_o
);
initial {extra_fault_o, fw_update_o, locate_o, fault_o, activity_o, power_on_o, link_o} = 8'h00;
always @(posedge clk_i) begin
    {extra_fault_o, fw_update_o, locate_o, fault_o, activity_o, power_on_o, link_o} <= req_i;
end
endmodule // status_src

/* test/panel_indicator_state_driver_tb.sv */
/*
 * Self-checking bench: register access over Wishbone, then a table of
 * status and mode cases whose lamp activity is counted over one period.
 * Assumes a blink half period of 8 cycles and two extra fault lamps.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin fails++; \
    $display("FAIL %s exp %h got %h", nm, e, g); end end
module panel_indicator_state_driver_tb;
logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, link_i, power_on_i, activity_i;
logic fault_i, locate_i, fw_update_i, blue_o, amber_o, comb_blue_o, comb_amber_o;
logic [3:0] adr_i, sel_i;
logic [31:0] dat_i, dat_o;
logic [1:0] extra_fault_i, extra_amber_o, mask;
logic [7:0] req;
int fails = 0, n_tests = 0;
logic [31:0] rd_q[$];
logic [9:0] lp_q[$];
event measure;
// ctrl, status {fw,locate,fault,act,power}, expected {ca,cb,a,b} behaviour
logic [17:0] rows[14] = '{18'h00000, 18'h00101, 18'h00302, 18'h00404, 18'h00808,
    18'h01101, 18'h02110, 18'h02320, 18'h02440, 18'h02880, 18'h031A0, 18'h10004,
    18'h08008, 18'h02540};
panel_indicator_state_driver #(.N_XFLT(2), .DEV_FEATURES(0), .HALF_PERIOD_CYCLES(8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .power_on_i(power_on_i), .link_i(link_i), .activity_i(activity_i),
    .fault_i(fault_i), .locate_i(locate_i), .fw_update_i(fw_update_i),
    .extra_fault_i(extra_fault_i), .blue_o(blue_o), .amber_o(amber_o),
    .comb_blue_o(comb_blue_o), .comb_amber_o(comb_amber_o), .extra_amber_o(extra_amber_o));
status_src src (.clk_i(clk_i), .req_i(req), .link_o(link_i), .power_on_o(power_on_i),
    .activity_o(activity_i), .fault_o(fault_i), .locate_o(locate_i),
    .fw_update_o(fw_update_i), .extra_fault_o(extra_fault_i));
////////////////////////////////////////////////////////////////////////////////
task end_of_test;
    if (fails == 0 && n_tests > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
// a read notes d as the expected data
task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
    if (!w) rd_q.push_back(d);
    do @(posedge clk_i); while (ack_o !== 1'b1);
    {cyc_i, stb_i, we_i} <= 3'b000;
endtask
function logic [19:0] want(input logic [7:0] e);
    for (int i = 0; i < 4; i++)
        want[i*5 +: 5] = (e[i*2 +: 2] == 2'h1) ? 5'h10 : (e[i*2 +: 2] == 2'h2) ? 5'h08 : 5'h00;
endfunction
////////////////////////////////////////////////////////////////////////////////
initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
end
initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    end_of_test;
end
// read data checked at the ack edge
initial begin
    logic [31:0] r;
    forever begin
        @(posedge clk_i);
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            r = rd_q.pop_front();
            `CHK("read data", r, dat_o)
        end
    end
end
// lit cycles over one full blink period: on 16, blink 8, off 0
initial begin
    logic [19:0] g;
    logic [9:0] e;
    forever begin
        @(measure);
        g = 20'h0;
        repeat (16) begin
            @(posedge clk_i);
            g = g + {4'h0, comb_amber_o, 4'h0, comb_blue_o, 4'h0, amber_o, 4'h0, blue_o};
        end
        e = lp_q.pop_front();
        `CHK("lamp counts", want(e[7:0]), g)
        `CHK("extra lamps", e[9:8], extra_amber_o)
    end
end
initial begin
    logic [1:0] xf;
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, req} = {1'b1, 51'h0};
    void'($urandom(32'h290C));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    wb(1'b0, 4'h4, 32'h3);
    wb(1'b0, 4'h2, 32'h0);
    wb(1'b1, 4'h0, 32'h1F);
    wb(1'b0, 4'h0, 32'h1D);
    mask = 2'($urandom);
    wb(1'b1, 4'h4, {30'h0, mask});
    wb(1'b0, 4'h4, {30'h0, mask});
    foreach (rows[i]) begin
        wb(1'b1, 4'h0, {27'h0, rows[i][17:13]});
        xf = 2'($urandom);
        req <= {xf, rows[i][12:8], 1'($urandom)};
        repeat (20) @(posedge clk_i);
        lp_q.push_back({xf & mask, rows[i][7:0]});
        -> measure;
        repeat (18) @(posedge clk_i);
    end
    end_of_test;
end
endmodule // panel_indicator_state_driver_tb
